// File: common/intu_consts.svh
// register offsets, field positions, reset values of the interrupt unit
// assumes: included by the design file and the testbench
`ifndef INTU_CONSTS_SVH
`define INTU_CONSTS_SVH
`define OFF_TIMER_CONTROL 8'h00
`define OFF_SERIAL_FLAGS 8'h04
`define OFF_INT_ENABLE 8'h08
`define OFF_PRIO_LOW 8'h0c
`define OFF_PRIO_HIGH 8'h10
`define OFF_EVENT_STATUS 8'h14
`define OFF_EVENT_MASK 8'h18
`define OFF_CORE_STATE 8'h1c
`define TC_EDGE_LSB 0
`define TC_EXTF_LSB 2
`define TC_TMRF_LSB 4
`define SF_RX_BIT 0
`define SF_TX_BIT 1
`define SF_T2_BIT 2
`define IE_GLOBAL_BIT 7
`define CS_HOLD_BIT 4
`define PIN_IDLE 2'b11
`define SRC_EXT0 3'h0
`define SRC_TMR0 3'h1
`define SRC_EXT1 3'h2
`define SRC_TMR1 3'h3
`define SRC_SERIAL 3'h4
`define SRC_TIMER2 3'h5
`endif

// File: common/intu_pkg.sv
// types shared by the interrupt unit and its surroundings
// assumes: intu_consts.svh sits beside it
package intu_pkg;
    typedef logic [1:0] level_t;
    typedef struct packed {
        logic final_cycle;
        logic reti;
    } core_in_s;
    typedef struct packed {
        logic valid;
        logic [2:0] src;
    } vector_s;
    typedef struct packed {
        logic [1:0] pin_meta;
        logic [1:0] pin_sync;
        logic [1:0] pin_prev;
        logic [1:0] edge_sel;
        logic [1:0] ext_flag;
        logic [1:0] tmr_flag;
        logic rx_flag;
        logic tx_flag;
        logic t2_flag;
        logic [5:0] en;
        logic ea;
        logic [5:0] ip_lo;
        logic [5:0] ip_hi;
        logic [3:0] active;
        logic hold;
        vector_s vec;
        logic [5:0] status;
        logic [5:0] mask;
        logic [31:0] rdata;
        logic slverr;
    } state_s;
endpackage

// File: hw/four_level_interrupt_unit.sv
// four level interrupt unit: six sources, enables, priority, vectoring
// assumes: apb master on pclk; core gives final_cycle/reti on pclk;
// external request pins are asynchronous and active low
`timescale 1ns/100ps
`include "intu_consts.svh"

module four_level_interrupt_unit
    import intu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [1:0] ext_request_pin_n,
    input wire logic [1:0] tmr_overflow,
    input wire logic rx_done_set,
    input wire logic tx_done_set,
    input wire logic timer2_set,
    input wire core_in_s core,
    output vector_s vector_out,
    output logic [3:0] active_levels,
    output logic irq
);

    // ****************************************
    // state and helpers
    // ****************************************
    state_s st_reg;
    state_s st_next;
    logic [5:0] req;
    logic [2:0] win;
    level_t wlvl;
    level_t cur;
    logic found;
    logic take;
    logic wr;
    logic cfg_wr;
    logic better;

    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction

    function automatic level_t lvl(input state_s s, input int i);
        return {s.ip_hi[i], s.ip_lo[i]};
    endfunction

    // ****************************************
    // arbitration
    // ****************************************
    always_comb begin
        req[0] = st_reg.ext_flag[0];
        req[1] = st_reg.tmr_flag[0];
        req[2] = st_reg.ext_flag[1];
        req[3] = st_reg.tmr_flag[1];
        req[4] = st_reg.rx_flag | st_reg.tx_flag;
        req[5] = st_reg.t2_flag;
        req = req & st_reg.en & {6{st_reg.ea}};
        found = 1'b0;
        win = 3'h0;
        wlvl = 2'h0;
        for (int i = 0; i < 6; i++) begin
            if (req[i] && (!found || lvl(st_reg, i) > wlvl)) begin
                found = 1'b1;
                win = 3'(i);
                wlvl = lvl(st_reg, i);
            end
        end
        // cross check from the raw priority bit planes
        better = (|(req & st_reg.ip_hi & st_reg.ip_lo) && wlvl != 2'h3)
            || (|(req & st_reg.ip_hi & ~st_reg.ip_lo) && wlvl < 2'h2)
            || (|(req & ~st_reg.ip_hi & st_reg.ip_lo) && wlvl == 2'h0);
        if (st_reg.active[3]) begin
            cur = 2'h3;
        end else if (st_reg.active[2]) begin
            cur = 2'h2;
        end else if (st_reg.active[1]) begin
            cur = 2'h1;
        end else begin
            cur = 2'h0;
        end
    end

    assign wr = ce & psel & penable & pwrite;
    assign cfg_wr = wr & (hit(paddr, `OFF_INT_ENABLE)
        | hit(paddr, `OFF_PRIO_LOW) | hit(paddr, `OFF_PRIO_HIGH));

    assign take = ce & core.final_cycle & ~core.reti & ~cfg_wr
        & ~st_reg.hold & found
        & (~|st_reg.active | (wlvl > cur));

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        if (ce) begin
            st_next.pin_meta = ext_request_pin_n;
            st_next.pin_sync = st_reg.pin_meta;
            st_next.pin_prev = st_reg.pin_sync;
            if (wr && hit(paddr, `OFF_TIMER_CONTROL)) begin
                st_next.edge_sel = pwdata[`TC_EDGE_LSB +: 2];
                st_next.ext_flag = pwdata[`TC_EXTF_LSB +: 2];
                st_next.tmr_flag = pwdata[`TC_TMRF_LSB +: 2];
            end
            if (wr && hit(paddr, `OFF_SERIAL_FLAGS)) begin
                st_next.rx_flag = pwdata[`SF_RX_BIT];
                st_next.tx_flag = pwdata[`SF_TX_BIT];
                st_next.t2_flag = pwdata[`SF_T2_BIT];
            end
            if (wr && hit(paddr, `OFF_INT_ENABLE)) begin
                st_next.en = pwdata[5:0];
                st_next.ea = pwdata[`IE_GLOBAL_BIT];
            end
            if (wr && hit(paddr, `OFF_PRIO_LOW)) begin
                st_next.ip_lo = pwdata[5:0];
            end
            if (wr && hit(paddr, `OFF_PRIO_HIGH)) begin
                st_next.ip_hi = pwdata[5:0];
            end
            if (wr && hit(paddr, `OFF_EVENT_STATUS)) begin
                st_next.status = st_reg.status & ~pwdata[5:0];
            end
            if (wr && hit(paddr, `OFF_EVENT_MASK)) begin
                st_next.mask = pwdata[5:0];
            end
            if (take) begin
                unique case (win)
                    `SRC_EXT0: begin
                        if (st_reg.edge_sel[0]) begin
                            st_next.ext_flag[0] = 1'b0;
                        end
                    end
                    `SRC_EXT1: begin
                        if (st_reg.edge_sel[1]) begin
                            st_next.ext_flag[1] = 1'b0;
                        end
                    end
                    `SRC_TMR0: st_next.tmr_flag[0] = 1'b0;
                    `SRC_TMR1: st_next.tmr_flag[1] = 1'b0;
                    default: ;
                endcase
            end
            st_next.tmr_flag = st_next.tmr_flag | tmr_overflow;
            if (rx_done_set) begin
                st_next.rx_flag = 1'b1;
            end
            if (tx_done_set) begin
                st_next.tx_flag = 1'b1;
            end
            if (timer2_set) begin
                st_next.t2_flag = 1'b1;
            end
            for (int i = 0; i < 2; i++) begin
                if (st_next.edge_sel[i]) begin
                    if (st_reg.pin_prev[i] && !st_reg.pin_sync[i]) begin
                        st_next.ext_flag[i] = 1'b1;
                    end
                end else begin
                    st_next.ext_flag[i] = ~st_reg.pin_sync[i];
                end
            end
            // routine nesting
            if (core.reti) begin
                if (st_reg.active[3]) begin
                    st_next.active[3] = 1'b0;
                end else if (st_reg.active[2]) begin
                    st_next.active[2] = 1'b0;
                end else if (st_reg.active[1]) begin
                    st_next.active[1] = 1'b0;
                end else begin
                    st_next.active[0] = 1'b0;
                end
            end
            if (take) begin
                st_next.active[wlvl] = 1'b1;
                st_next.status[win] = 1'b1;
            end
            // one more instruction after a config write
            if (cfg_wr) begin
                st_next.hold = 1'b1;
            end else if (core.final_cycle) begin
                st_next.hold = 1'b0;
            end
            st_next.vec.valid = take;
            st_next.vec.src = win;
            // read data captured in the setup phase
            if (psel && !penable) begin
                st_next.slverr = 1'b0;
                st_next.rdata = 32'h0;
                if (hit(paddr, `OFF_TIMER_CONTROL)) begin
                    st_next.rdata[5:0] = {st_reg.tmr_flag,
                        st_reg.ext_flag, st_reg.edge_sel};
                end else if (hit(paddr, `OFF_SERIAL_FLAGS)) begin
                    st_next.rdata[2:0] = {st_reg.t2_flag,
                        st_reg.tx_flag, st_reg.rx_flag};
                end else if (hit(paddr, `OFF_INT_ENABLE)) begin
                    st_next.rdata[7:0] = {st_reg.ea, 1'b0, st_reg.en};
                end else if (hit(paddr, `OFF_PRIO_LOW)) begin
                    st_next.rdata[5:0] = st_reg.ip_lo;
                end else if (hit(paddr, `OFF_PRIO_HIGH)) begin
                    st_next.rdata[5:0] = st_reg.ip_hi;
                end else if (hit(paddr, `OFF_EVENT_STATUS)) begin
                    st_next.rdata[5:0] = st_reg.status;
                end else if (hit(paddr, `OFF_EVENT_MASK)) begin
                    st_next.rdata[5:0] = st_reg.mask;
                end else if (hit(paddr, `OFF_CORE_STATE)) begin
                    st_next.rdata[4:0] = {st_reg.hold, st_reg.active};
                end else begin
                    st_next.slverr = 1'b1;
                end
            end
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.pin_meta <= `PIN_IDLE;
            st_reg.pin_sync <= `PIN_IDLE;
            st_reg.pin_prev <= `PIN_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pready = ce;
    assign prdata = st_reg.rdata;
    assign pslverr = st_reg.slverr;
    assign vector_out = st_reg.vec;
    assign active_levels = st_reg.active;
    assign irq = |(st_reg.status & st_reg.mask);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    enabled_only_a: assert property (take |->
        st_reg.en[win] && st_reg.ea)
        else $error("disabled source vectored");
    strict_preempt_a: assert property (take && |st_reg.active |->
        wlvl > cur)
        else $error("same or lower level preempted");
    top_level_a: assert property (st_reg.active[3] |-> !take)
        else $error("level 3 routine preempted");
    level_order_a: assert property (take |-> !better)
        else $error("higher level request passed over");
    block_cond_a: assert property ((core.reti || st_reg.hold
        || !core.final_cycle) |-> !take)
        else $error("vectoring while blocked");
    ext_clear_a: assert property (take && win == `SRC_EXT0
        && st_reg.edge_sel[0] && !wr
        && !(st_reg.pin_prev[0] && !st_reg.pin_sync[0])
        |=> !st_reg.ext_flag[0])
        else $error("edge flag not cleared on vectoring");
    tmr_clear_a: assert property (take && win == `SRC_TMR0
        && !tmr_overflow[0] && !wr |=> !st_reg.tmr_flag[0])
        else $error("timer flag not cleared on vectoring");
    serial_kept_a: assert property (take && win == `SRC_SERIAL
        && st_reg.rx_flag && !wr |=> st_reg.rx_flag)
        else $error("serial flag cleared by vectoring");
    edge_set_a: assert property (ce && st_reg.edge_sel[1]
        && st_reg.pin_prev[1] && !st_reg.pin_sync[1]
        |=> st_reg.ext_flag[1])
        else $error("falling edge missed");
    // vector output follows take
    vector_pulse_a: assert property (take |=> vector_out.valid
        && vector_out.src == $past(win))
        else $error("vector output wrong");

    cover_ext0_c: cover property (take && win == `SRC_EXT0);
    cover_preempt_c: cover property (take && |st_reg.active);
    cover_reti_c: cover property (core.reti && |st_reg.active);
    cover_irq_c: cover property (irq);

endmodule // four_level_interrupt_unit

// File: bench/core_model.sv
// core sequencer model: final-cycle and return indications to the unit
// assumes: commanded by tb on pclk; stall low ends an instruction each cycle
`timescale 1ns/100ps

module core_model
    import intu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic ret_req,
    output core_in_s core
);
    // final cycle only when not stalled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core <= '0;
        end else begin
            core.final_cycle <= !stall;
            core.reti <= ret_req & !stall;
        end
    end
endmodule // core_model

// File: bench/tb.sv
// testbench of the four level interrupt unit over apb
// assumes: intu_pkg compiled first, intu_consts.svh on the include path
`timescale 1ns/100ps
`include "intu_consts.svh"

module tb
    import intu_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
    logic rx_set, tx_set, t2_set, stall, ret_req, ce;
    logic [3:0] act;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, nvec, nexp, errors, checks, q;
    logic [1:0] pin_n, tmr_ov;
    logic [2:0] last_src;
    core_in_s core;
    vector_s vec;

    four_level_interrupt_unit u_four_level_interrupt_unit (
        .pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ext_request_pin_n(pin_n), .tmr_overflow(tmr_ov),
        .rx_done_set(rx_set), .tx_done_set(tx_set), .timer2_set(t2_set),
        .core(core), .vector_out(vec), .active_levels(act), .irq(irq));

    core_model u_core_model (.pclk(pclk), .presetn(presetn), .stall(stall),
        .ret_req(ret_req), .core(core));

    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (vec.valid === 1'h1) begin
            nvec <= nvec + 1;
            last_src <= vec.src;
        end
    end

    // ****************************************************************
    // tasks
    // ****************************************************************
    task check(input string name, input logic [31:0] seen, exp);
        checks = checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task finish_test;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        q = prdata;
        slv = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask

    task rd(input string name, input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        check(name, q, e);
    endtask

    task wait_vec(input logic [2:0] s);
        nexp = nexp + 1;
        for (int i = 0; i < 30 && nvec < nexp; i++) @(posedge pclk);
        repeat (4) @(posedge pclk);
        check("vector count", nvec, nexp);
        check("vector source", {29'h0, last_src}, {29'h0, s});
    endtask

    task no_vec;
        repeat (10) @(posedge pclk);
        check("vector count", nvec, nexp);
    endtask

    task reti;
        @(posedge pclk);
        ret_req <= 1'h1;
        @(posedge pclk);
        ret_req <= 1'h0;
        repeat (2) @(posedge pclk);
    endtask

    task run_order(input logic [5:0] lo, hi, input logic [11:0] ord);
        wr(`OFF_INT_ENABLE, 32'h0f);
        wr(`OFF_PRIO_LOW, {26'h0, lo});
        wr(`OFF_PRIO_HIGH, {26'h0, hi});
        wr(`OFF_TIMER_CONTROL, 32'h3f);
        wr(`OFF_INT_ENABLE, 32'h8f);
        for (int i = 0; i < 4; i++) begin
            wait_vec(ord[i*3+:3]);
            reti();
        end
        rd("flags", `OFF_TIMER_CONTROL, 32'h03);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {presetn, psel, penable, pwrite, stall, ret_req} = '0;
        {rx_set, tx_set, t2_set, tmr_ov} = '0;
        {paddr, pwdata, nvec, nexp, errors, checks} = '0;
        pin_n = 2'h3;
        ce = 1'h1;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        rd("enable", `OFF_INT_ENABLE, 32'h0);
        rd("unmapped", 8'h20, 32'h0);
        check("slverr", {31'h0, slv}, 32'h1);
        wr(`OFF_EVENT_MASK, 32'h3f);
        wr(`OFF_INT_ENABLE, 32'h82);
        @(posedge pclk);
        stall <= 1'h1;
        tmr_ov <= 2'h1;
        @(posedge pclk);
        tmr_ov <= 2'h0;
        no_vec();
        rd("timer flag", `OFF_TIMER_CONTROL, 32'h10);
        stall <= 1'h0;
        wait_vec(3'h1);
        check("active", {28'h0, act}, 32'h1);
        rd("timer flag", `OFF_TIMER_CONTROL, 32'h0);
        check("irq", {31'h0, irq}, 32'h1);
        rd("status", `OFF_EVENT_STATUS, 32'h02);
        wr(`OFF_EVENT_STATUS, 32'h02);
        @(posedge pclk);
        check("irq", {31'h0, irq}, 32'h0);
        reti();
        check("active", {28'h0, act}, 32'h0);
        wr(`OFF_INT_ENABLE, 32'h8e);
        wr(`OFF_TIMER_CONTROL, 32'h07);
        no_vec();
        rd("ext flag", `OFF_TIMER_CONTROL, 32'h07);
        wr(`OFF_INT_ENABLE, 32'h01);
        no_vec();
        wr(`OFF_INT_ENABLE, 32'h81);
        wait_vec(3'h0);
        reti();
        run_order(6'h0a, 6'h0c, {3'h0, 3'h1, 3'h2, 3'h3});
        run_order(6'h00, 6'h00, {3'h3, 3'h2, 3'h1, 3'h0});
        wr(`OFF_INT_ENABLE, 32'hb0);
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            {t2_set, tx_set, rx_set} <= 3'h1 << i;
            @(posedge pclk);
            {t2_set, tx_set, rx_set} <= 3'h0;
            wait_vec(i == 2 ? 3'h5 : 3'h4);
            rd("serial flags", `OFF_SERIAL_FLAGS, 32'h1 << i);
            wr(`OFF_SERIAL_FLAGS, 32'h0);
            reti();
        end
        wr(`OFF_TIMER_CONTROL, 32'h0);
        wr(`OFF_INT_ENABLE, 32'h81);
        // source holds level request until called
        pin_n <= 2'h2;
        wait_vec(3'h0);
        rd("level flag", `OFF_TIMER_CONTROL, 32'h04);
        pin_n <= 2'h3;
        reti();
        wr(`OFF_TIMER_CONTROL, 32'h02);
        wr(`OFF_INT_ENABLE, 32'h84);
        pin_n <= 2'h1;
        wait_vec(3'h2);
        rd("edge flag", `OFF_TIMER_CONTROL, 32'h02);
        pin_n <= 2'h3;
        reti();
        // freeze: a timer pulse while the clock enable is low is lost
        @(posedge pclk);
        ce <= 1'h0;
        tmr_ov <= 2'h2;
        @(posedge pclk);
        tmr_ov <= 2'h0;
        check("pready", {31'h0, pready}, 32'h0);
        @(posedge pclk);
        ce <= 1'h1;
        rd("frozen flag", `OFF_TIMER_CONTROL, 32'h02);
        finish_test();
    end

    initial begin
        repeat (6000) @(posedge pclk);
        errors = errors + 1;
        finish_test();
    end
endmodule // tb
